// ==== wps_pkg.sv ====
// shared constants, types and tables of the wireless power supervisor
package wps_pkg;

    // ********************************************
    // clock and time base
    // ********************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int TONE_HZ = 4000;
    localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int MS_W = 19;

    // ********************************************
    // durations
    // ********************************************
    localparam int TONE_MS = 400;
    localparam int HOLD_CHARGED_S = 5;
    localparam int HOLD_LONG_MIN = 5;
    localparam int RETRY_FAST_MS = 500;
    localparam int RECHAR_MS = 1000;
    localparam int NO_PKT_MS = 1800;
    localparam int POR_MS = 10;
    localparam logic [MS_W-1:0] HOLD_CHARGED = MS_W'(HOLD_CHARGED_S * MS_PER_S);
    localparam logic [MS_W-1:0] HOLD_LONG = MS_W'(HOLD_LONG_MIN * S_PER_MIN * MS_PER_S);
    localparam logic [MS_W-1:0] HOLD_FAST = MS_W'(RETRY_FAST_MS);
    localparam logic [MS_W-1:0] RECHAR_LEN = MS_W'(RECHAR_MS);
    localparam logic [MS_W-1:0] NO_PKT_LEN = MS_W'(NO_PKT_MS);
    localparam logic [MS_W-1:0] POR_LEN = MS_W'(POR_MS);
    localparam logic [MS_W-1:0] TONE_LEN = MS_W'(TONE_MS);

    // ********************************************
    // operating point
    // ********************************************
    localparam logic [7:0] FREQ_MIN_KHZ = 8'd110;
    localparam logic [7:0] FREQ_MAX_KHZ = 8'd205;
    localparam logic [7:0] FREQ_CAP_KHZ = 8'd190;
    localparam logic [7:0] FREQ_START_KHZ = 8'd175;
    localparam logic [6:0] DUTY_NOM_PCT = 7'd50;
    localparam logic [6:0] DUTY_MIN_PCT = 7'd10;

    // ********************************************
    // packet headers and codes
    // ********************************************
    localparam logic [7:0] HDR_EPT = 8'h02;
    localparam logic [7:0] HDR_CEP = 8'h03;
    localparam logic [7:0] HDR_CS = 8'h05;
    localparam logic [7:0] EPT_CHARGED = 8'h01;
    localparam logic [7:0] EPT_INTERNAL = 8'h02;
    localparam logic [7:0] EPT_OVER_TEMP = 8'h03;
    localparam logic [7:0] EPT_BATTERY = 8'h06;
    localparam logic [7:0] CS_FULL = 8'd100;
    localparam logic [7:0] CS_REARM = 8'd90;

    // ********************************************
    // types
    // ********************************************
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_PING = 3'b001,
        ST_POWER = 3'b010,
        ST_HOLD = 3'b011,
        ST_LOCK = 3'b100
    } wps_state_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_HDR = 2'b01,
        PS_MSG = 2'b10,
        PS_SUM = 2'b11
    } wps_parse_t;

    typedef enum logic [2:0] {
        IND_IDLE = 3'b000,
        IND_POWER = 3'b001,
        IND_CHARGED = 3'b010,
        IND_FAULT = 3'b011,
        IND_DROOP = 3'b100,
        IND_LOCK = 3'b101
    } wps_ind_t;

    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
    } wps_demod_t;

    typedef struct packed {
        logic [7:0] freq_khz;
        logic [6:0] duty_pct;
    } wps_drive_t;

    // led pattern per lamp: 00 off, 01 on, 10 slow blink, 11 fast blink; {c, b, a}
    localparam logic [5:0] IND_TABLE [4][6] = '{
        '{6'h00, 6'h02, 6'h01, 6'h0C, 6'h30, 6'h04},
        '{6'h00, 6'h01, 6'h03, 6'h08, 6'h0C, 6'h0F},
        '{6'h00, 6'h02, 6'h11, 6'h30, 6'h22, 6'h3F},
        '{6'h00, 6'h01, 6'h05, 6'h0C, 6'h10, 6'h0A}
    };

endpackage : wps_pkg

// ==== wps_sync.sv ====
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module wps_sync
    import wps_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] rst_val,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1 <= rst_val;
            pin_sync <= rst_val;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end

endmodule : wps_sync

// ==== wps_supervisor.sv ====
// supervisory control of the inductive power transmitter
// Contract
// - hold 5 s charged, 5 min hot, never fault
// - retry within a second on fast faults
// - led pattern picked by indicator scheme
// - recharacterize field for a second after fault
// - stale field keeps fault until retry/new receiver
// - one 400 ms 4 kHz start tone
// - hold reset until supply valid, then start
// - charge complete message stops power, shows charged
// - full charge status shows charged, keeps power
// - status below 90 restores charging indication
// - regulate frequency within 110 to 205 kHz
// - duty stays half until top frequency
// - supply droop limits operating point
// - droop limiting shows its own pattern
// - negative control error ends droop limiting
// - cap select low caps at 190 kHz
// - cap select high means full band
// - packet parsed preamble, header, message, checksum
// - control error packets move operating point
// - sense shutdown resumes after 5 min or removal
`timescale 1ns/10ps
module wps_supervisor
    import wps_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic supply_good,
    input wire logic rx_present,
    input wire logic ext_sense_low,
    input wire logic tx_over_volt,
    input wire logic tx_over_temp,
    input wire logic internal_fault,
    input wire logic supply_droop,
    input wire logic freq_cap_select,
    input wire logic [1:0] indicator_scheme_select,
    input wire wps_demod_t demod,
    output wps_drive_t drive,
    output logic power_enable,
    output logic field_scan,
    output logic audible_start_tone,
    output logic [2:0] led
);
    // ********************************************
    // pin synchronisers
    // ********************************************
    logic [9:0] pins_sync;
    logic good_s, rx_s, sense_s, ovp_s, otp_s, int_s, droop_s, cap_s;
    logic [1:0] scheme_s;

    wps_sync #(.WIDTH(10)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in({indicator_scheme_select, freq_cap_select, supply_droop, internal_fault,
                 tx_over_temp, tx_over_volt, ext_sense_low, rx_present, supply_good}),
        .rst_val(10'h080),
        .pin_sync(pins_sync)
    );
    assign {scheme_s, cap_s, droop_s, int_s, otp_s, ovp_s, sense_s, rx_s, good_s} = pins_sync;

    // ********************************************
    // millisecond time base
    // ********************************************
    logic [$clog2(CYC_MS)-1:0] cyc_cnt;
    logic ms_tick;
    logic [9:0] blink_ms;

    assign ms_tick = (cyc_cnt == ($clog2(CYC_MS))'(CYC_MS - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst || ms_tick) begin
            cyc_cnt <= '0;
        end else begin
            cyc_cnt <= cyc_cnt + 1'b1;
        end
        blink_ms <= sys_rst ? 10'h000 : blink_ms + 10'(ms_tick);
    end

    // ********************************************
    // packet parser
    // ********************************************
    wps_parse_t ps;
    logic [7:0] pkt_hdr, pkt_b0, pkt_sum;
    logic [2:0] pkt_left;
    logic pkt_ok, pkt_bad;

    always_ff @(posedge clk_sys) begin
        pkt_ok <= 1'b0;
        pkt_bad <= 1'b0;
        if (sys_rst) begin
            ps <= PS_IDLE;
            pkt_hdr <= 8'h00;
            pkt_b0 <= 8'h00;
            pkt_sum <= 8'h00;
            pkt_left <= 3'h0;
        end else if (demod.start) begin
            ps <= PS_HDR;
        end else if (demod.valid) begin
            unique case (ps)
                PS_IDLE: ps <= PS_IDLE;
                PS_HDR: begin
                    pkt_hdr <= demod.data;
                    pkt_sum <= demod.data;
                    pkt_left <= demod.data[7:5];
                    ps <= PS_MSG;
                end
                PS_MSG: begin
                    if (pkt_left == pkt_hdr[7:5]) begin
                        pkt_b0 <= demod.data;
                    end
                    pkt_sum <= pkt_sum ^ demod.data;
                    pkt_left <= pkt_left - 3'h1;
                    ps <= (pkt_left == 3'h0) ? PS_SUM : PS_MSG;
                end
                PS_SUM: begin
                    pkt_ok <= (pkt_sum == demod.data);
                    pkt_bad <= (pkt_sum != demod.data);
                    ps <= PS_IDLE;
                end
            endcase
        end
    end

    // ********************************************
    // decode of messages and terminations
    // ********************************************
    wps_state_t state;
    logic [MS_W-1:0] hold_ms, rechar_ms, pkt_ms, por_ms, tone_ms;
    logic hold_fault, hold_rm, stale, rx_d, charged, droop_mode;
    wire in_pwr = (state == ST_POWER);
    wire ept = pkt_ok && (pkt_hdr == HDR_EPT);
    wire cep = pkt_ok && (pkt_hdr == HDR_CEP);
    wire cs = pkt_ok && (pkt_hdr == HDR_CS);
    wire ept_lock = ept && (pkt_b0 == EPT_INTERNAL || pkt_b0 == EPT_BATTERY);
    wire ept_long = ept && (pkt_b0 == EPT_OVER_TEMP);
    wire ept_chg = ept && (pkt_b0 == EPT_CHARGED);
    wire ept_fast = ept && !ept_lock && !ept_long && !ept_chg;
    wire t_lock = in_pwr && (int_s || ept_lock);
    wire t_long = in_pwr && (otp_s || sense_s || ept_long);
    wire t_fast = in_pwr && (ovp_s || ept_fast || pkt_ms >= NO_PKT_LEN);
    wire t_chg = in_pwr && ept_chg;
    wire term = t_lock || t_long || t_fast || t_chg;
    wire [MS_W-1:0] hold_load = t_long ? HOLD_LONG : (t_fast ? HOLD_FAST : HOLD_CHARGED);
    wire rx_gone = rx_d && !rx_s;
    wire rx_new = rx_s && !rx_d;
    wire start_pwr = (state == ST_PING) && rx_s && !sense_s;

    // ********************************************
    // main sequence
    // ********************************************
    always_ff @(posedge clk_sys) begin
        rx_d <= sys_rst ? 1'b0 : rx_s;
        if (sys_rst || !good_s) begin
            state <= ST_RESET;
            por_ms <= '0;
            hold_ms <= '0;
            hold_fault <= 1'b0;
            hold_rm <= 1'b0;
        end else begin
            unique case (state)
                ST_RESET: begin
                    por_ms <= por_ms + MS_W'(ms_tick);
                    if (por_ms >= POR_LEN) state <= ST_PING;
                end
                ST_PING: if (start_pwr) state <= ST_POWER;
                ST_POWER: begin
                    if (t_lock) begin
                        state <= ST_LOCK;
                    end else if (term) begin
                        state <= ST_HOLD;
                        hold_ms <= hold_load;
                        hold_fault <= !(t_chg && !t_long && !t_fast);
                        hold_rm <= sense_s && !otp_s;
                    end
                end
                ST_HOLD: begin
                    if (hold_ms == '0 || (hold_rm && rx_gone)) begin
                        state <= ST_PING;
                    end
                    hold_ms <= hold_ms - MS_W'(ms_tick && hold_ms != '0);
                end
                ST_LOCK: state <= ST_LOCK;
                default: state <= ST_RESET;
            endcase
        end
    end

    // ********************************************
    // field recharacterization and stale fault view
    // ********************************************
    wire hold_entry = in_pwr && term && !t_lock;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || hold_entry && !(t_chg && !t_long && !t_fast)) begin
            rechar_ms <= sys_rst ? '0 : RECHAR_LEN;
        end else begin
            rechar_ms <= rechar_ms - MS_W'(ms_tick && rechar_ms != '0);
        end
        if (sys_rst || state != ST_HOLD || rx_new) begin
            stale <= 1'b0;
        end else if (rx_gone && rechar_ms != '0) begin
            stale <= 1'b1;
        end
    end
    assign field_scan = (rechar_ms != '0);

    // ********************************************
    // charge status, droop and packet watchdog
    // ********************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !in_pwr) begin
            charged <= 1'b0;
            droop_mode <= 1'b0;
            pkt_ms <= '0;
        end else begin
            if (cs && pkt_b0 >= CS_FULL) charged <= 1'b1;
            if (cs && pkt_b0 < CS_REARM) charged <= 1'b0;
            if (cep && pkt_b0[7]) begin
                droop_mode <= 1'b0;
            end else if (droop_s) begin
                droop_mode <= 1'b1;
            end
            pkt_ms <= pkt_ok ? '0 : pkt_ms + MS_W'(ms_tick);
        end
    end

    // ********************************************
    // operating point
    // ********************************************
    wire [7:0] f_top = cap_s ? FREQ_MAX_KHZ : FREQ_CAP_KHZ;
    wire less = (cep && pkt_b0[7]) || (droop_s && ms_tick && !(cep && pkt_b0[7]));
    wire more = cep && !pkt_b0[7] && pkt_b0 != 8'h00 && !droop_mode;
    wire [7:0] f_clamp = (drive.freq_khz > f_top) ? f_top : drive.freq_khz;
    logic [7:0] next_freq;
    logic [6:0] next_duty;

    assign next_freq = !in_pwr ? FREQ_START_KHZ :
        (less && f_clamp < f_top) ? f_clamp + 8'd1 :
        (more && drive.duty_pct == DUTY_NOM_PCT && f_clamp > FREQ_MIN_KHZ) ?
        f_clamp - 8'd1 : f_clamp;
    assign next_duty = !in_pwr ? DUTY_NOM_PCT :
        (f_clamp != FREQ_MAX_KHZ) ? DUTY_NOM_PCT :
        (less && f_clamp == FREQ_MAX_KHZ && drive.duty_pct > DUTY_MIN_PCT) ?
        drive.duty_pct - 7'd1 :
        (more && drive.duty_pct < DUTY_NOM_PCT) ? drive.duty_pct + 7'd1 : drive.duty_pct;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            drive <= '{freq_khz: FREQ_START_KHZ, duty_pct: DUTY_NOM_PCT};
        end else begin
            drive <= '{freq_khz: next_freq, duty_pct: next_duty};
        end
    end
    assign power_enable = in_pwr;

    // ********************************************
    // start tone
    // ********************************************
    logic [$clog2(TONE_HALF_CYC)-1:0] tone_cyc;
    logic tone_lvl;
    wire tone_half = (tone_cyc == ($clog2(TONE_HALF_CYC))'(TONE_HALF_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tone_ms <= '0;
            tone_cyc <= '0;
            tone_lvl <= 1'b0;
        end else if (start_pwr && good_s) begin
            tone_ms <= TONE_LEN;
            tone_cyc <= '0;
            tone_lvl <= 1'b1;
        end else if (tone_ms != '0) begin
            tone_ms <= tone_ms - MS_W'(ms_tick);
            tone_cyc <= tone_half ? '0 : tone_cyc + 1'b1;
            tone_lvl <= tone_lvl ^ tone_half;
        end else begin
            tone_lvl <= 1'b0;
        end
    end
    assign audible_start_tone = tone_lvl;

    // ********************************************
    // indication
    // ********************************************
    logic [1:0] scheme;
    wps_ind_t ind;
    wire [5:0] pat = IND_TABLE[scheme][ind];

    assign ind = (state == ST_LOCK) ? IND_LOCK :
        (in_pwr && droop_mode) ? IND_DROOP :
        (in_pwr && charged) ? IND_CHARGED :
        in_pwr ? IND_POWER :
        (state == ST_HOLD && !hold_fault) ? IND_CHARGED :
        (state == ST_HOLD && (rx_s || stale)) ? IND_FAULT : IND_IDLE;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scheme <= 2'h0;
        end else if (state == ST_RESET) begin
            scheme <= scheme_s;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_led
            wire [1:0] p = pat[2*gi +: 2];
            always_ff @(posedge clk_sys) begin
                led[gi] <= !sys_rst && (p == 2'b01 || (p == 2'b10 && blink_ms[9]) ||
                    (p == 2'b11 && blink_ms[7]));
            end
        end
    endgenerate

    // ********************************************
    // checks
    // ********************************************
    a_freq_band: assert property (@(posedge clk_sys) disable iff (sys_rst)
        in_pwr |=> drive.freq_khz >= FREQ_MIN_KHZ && drive.freq_khz <= FREQ_MAX_KHZ)
        else $error("drive frequency left band");
    a_freq_cap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cap_s && $past(!cap_s) |-> drive.freq_khz <= FREQ_CAP_KHZ)
        else $error("frequency above cap");
    a_duty_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
        drive.duty_pct < DUTY_NOM_PCT |-> drive.freq_khz == FREQ_MAX_KHZ)
        else $error("duty reduced below top frequency");
    a_tone_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        start_pwr && good_s |=> tone_ms == TONE_LEN ##1 tone_lvl)
        else $error("start tone not launched");
    a_ept_charge: assert property (@(posedge clk_sys) disable iff (sys_rst || !good_s)
        t_chg && !t_lock && !t_long && !t_fast |=> state == ST_HOLD && !power_enable
        && hold_ms == HOLD_CHARGED ##1 ind == IND_CHARGED)
        else $error("charge complete not handled");
    a_cs_full: assert property (@(posedge clk_sys) disable iff (sys_rst || !good_s)
        in_pwr && cs && pkt_b0 >= CS_FULL && !term |=> charged && power_enable)
        else $error("full status mishandled");
    a_cs_rearm: assert property (@(posedge clk_sys) disable iff (sys_rst || !good_s)
        cs && pkt_b0 < CS_REARM && !term |=> !charged)
        else $error("charging indication not restored");
    a_droop_exit: assert property (@(posedge clk_sys) disable iff (sys_rst || !good_s)
        droop_mode && cep && pkt_b0[7] && !term |=> !droop_mode ##1 ind != IND_DROOP)
        else $error("negative error kept droop limiting");
    a_lock_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == ST_LOCK && good_s |=> state == ST_LOCK [*8])
        else $error("lockout released");
    a_bad_sum: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pkt_bad && in_pwr && !droop_s && drive.freq_khz <= f_top |=> $stable(drive))
        else $error("bad checksum accepted");
    a_fast_hold: assert property (@(posedge clk_sys) disable iff (sys_rst || !good_s)
        t_fast && !t_lock && !t_long |=> hold_ms == HOLD_FAST)
        else $error("fast retry wait wrong");

endmodule : wps_supervisor

// ==== wps_rx_model.sv ====
// receiver packet source seen through the demodulating front end
`timescale 1ns/10ps
module wps_rx_model
    import wps_pkg::*;
(
    input wire logic clk_sys,
    output wps_demod_t demod
);
    logic [7:0] last;

    initial begin
        demod = '0;
        last = 8'h00;
    end

    // ********************************************
    // byte delivery, one per cycle
    // ********************************************
    task automatic put(input logic st, input logic vl, input logic [7:0] d);
        @(posedge clk_sys);
        demod <= '{start: st, valid: vl, data: d};
        if (vl) begin
            last = d;
        end
    endtask : put

    // idle data shows the inverse of the last byte, never a stale copy
    task automatic send(input logic [7:0] hdr, input logic [7:0] val, input logic bad);
        logic [7:0] sum;
        sum = hdr ^ val ^ {7'h00, bad};
        put(1'b1, 1'b0, ~last);
        put(1'b0, 1'b1, hdr);
        put(1'b0, 1'b1, val);
        put(1'b0, 1'b1, sum);
        put(1'b0, 1'b0, ~sum);
    endtask : send
endmodule : wps_rx_model

// ==== wireless_tx_power_supervisor_tb.sv ====
// self-checking bench of the power supervisor
`timescale 1ns/10ps
module wireless_tx_power_supervisor_tb
    import wps_pkg::*;
;
    localparam int MS = 20;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_good = 1'b1;
    logic rx_present = 1'b1;
    logic ext_sense_low = 1'b0;
    logic tx_over_volt = 1'b0;
    logic tx_over_temp = 1'b0;
    logic internal_fault = 1'b0;
    logic supply_droop = 1'b0;
    logic freq_cap_select = 1'b1;
    logic [1:0] scheme = 2'h0;
    wps_demod_t demod;
    wps_drive_t drive;
    logic power_enable;
    logic field_scan;
    logic audible_start_tone;
    logic [2:0] led;
    int n_mismatch = 0;
    int checked = 0;
    int n;

    always #20 clk_sys = ~clk_sys;

    wps_rx_model i_rx (.clk_sys(clk_sys), .demod(demod));

    wps_supervisor #(.CYC_MS(MS)) i_dut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .supply_good(supply_good),
        .rx_present(rx_present),
        .ext_sense_low(ext_sense_low),
        .tx_over_volt(tx_over_volt),
        .tx_over_temp(tx_over_temp),
        .internal_fault(internal_fault),
        .supply_droop(supply_droop),
        .freq_cap_select(freq_cap_select),
        .indicator_scheme_select(scheme),
        .demod(demod),
        .drive(drive),
        .power_enable(power_enable),
        .field_scan(field_scan),
        .audible_start_tone(audible_start_tone),
        .led(led)
    );

    // ********************************************
    // shared tasks
    // ********************************************
    task automatic complete_run;
        $display("counts: mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic cycles(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cycles

    task automatic wait_pwr(input logic lvl, input int lim);
        n = 0;
        while (power_enable !== lvl) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("mismatch at %0t: power wait ran out", $time);
                complete_run();
            end
        end
    endtask : wait_pwr

    task automatic pkt(input logic [7:0] h, input logic [7:0] v, input logic bad, input int k);
        repeat (k) i_rx.send(h, v, bad);
        cycles(3);
    endtask : pkt

    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_startup;
        check(drive === {FREQ_START_KHZ, DUTY_NOM_PCT}, "reset drive");
        cycles(9 * MS);
        check(power_enable === 1'b0, "power before start delay");
        wait_pwr(1'b1, 6 * MS);
        cycles(3);
        check(audible_start_tone === 1'b1, "no start tone");
        n = 0;
        while (audible_start_tone === 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        check(n >= TONE_HALF_CYC - 5 && n <= TONE_HALF_CYC + 1, "tone half period");
        cycles(400 * MS);
        check(audible_start_tone === 1'b0, "tone too long");
        $display("test startup done");
    endtask : t_startup

    task automatic t_cep;
        pkt(HDR_CEP, 8'hFF, 1'b0, 1);
        check(drive.freq_khz === 8'd176, "negative step");
        pkt(HDR_CEP, 8'h01, 1'b0, 1);
        check(drive.freq_khz === 8'd175, "positive step");
        pkt(HDR_CEP, 8'hFF, 1'b1, 1);
        check(drive.freq_khz === 8'd175, "bad sum acted on");
        $display("test control error done");
    endtask : t_cep

    task automatic t_status;
        pkt(HDR_CS, CS_FULL, 1'b0, 1);
        check(led === 3'b001 && power_enable === 1'b1, "full charge");
        pkt(HDR_CS, 8'd95, 1'b0, 1);
        check(led === 3'b001, "charged left above rearm");
        pkt(HDR_CS, 8'd89, 1'b0, 1);
        n = 0;
        while (led !== 3'b000 && n < 1100 * MS) begin
            @(posedge clk_sys);
            n++;
        end
        check(n < 1100 * MS, "charging lamps not back");
        $display("test charge status done");
    endtask : t_status

    task automatic t_cap;
        freq_cap_select <= 1'b0;
        pkt(HDR_CEP, 8'hFF, 1'b0, 20);
        check(drive === {FREQ_CAP_KHZ, DUTY_NOM_PCT}, "capped band");
        freq_cap_select <= 1'b1;
        pkt(HDR_CEP, 8'hFF, 1'b0, 20);
        check(drive === {FREQ_MAX_KHZ, 7'd45}, "top of band");
        pkt(HDR_CEP, 8'h01, 1'b0, 6);
        check(drive === {8'd204, DUTY_NOM_PCT}, "leave top");
        $display("test frequency cap done");
    endtask : t_cap

    task automatic t_droop;
        int hi_c;
        int hi_ab;
        hi_c = 0;
        hi_ab = 0;
        supply_droop <= 1'b1;
        cycles(10 * MS);
        repeat (290 * MS) begin
            @(posedge clk_sys);
            hi_c += int'(led[2] === 1'b1);
            hi_ab += int'(led[1:0] !== 2'b00);
        end
        check(drive === {FREQ_MAX_KHZ, DUTY_MIN_PCT}, "droop limit point");
        check(hi_c > 0 && hi_ab == 0, "droop lamps");
        supply_droop <= 1'b0;
        cycles(5);
        pkt(HDR_CEP, 8'h01, 1'b0, 1);
        check(drive.duty_pct === DUTY_MIN_PCT, "raise obeyed while limiting");
        pkt(HDR_CEP, 8'hFF, 1'b0, 1);
        pkt(HDR_CEP, 8'h01, 1'b0, 1);
        check(drive.duty_pct === 7'd11, "normal loop not back");
        $display("test droop done");
    endtask : t_droop

    task automatic t_retry;
        tx_over_volt <= 1'b1;
        wait_pwr(1'b0, 10);
        tx_over_volt <= 1'b0;
        cycles(5);
        check(field_scan === 1'b1, "no field rescan");
        wait_pwr(1'b1, 1000 * MS);
        $display("test fast retry done");
    endtask : t_retry

    task automatic t_sense;
        ext_sense_low <= 1'b1;
        wait_pwr(1'b0, 10);
        ext_sense_low <= 1'b0;
        cycles(600 * MS);
        check(power_enable === 1'b0, "sense hold too short");
        rx_present <= 1'b0;
        cycles(10);
        rx_present <= 1'b1;
        wait_pwr(1'b1, 10 * MS);
        $display("test sense shutdown done");
    endtask : t_sense

    task automatic t_charged;
        pkt(HDR_EPT, EPT_CHARGED, 1'b0, 1);
        check(power_enable === 1'b0 && led === 3'b001, "charge complete");
        cycles(1000 * MS);
        check(power_enable === 1'b0, "early retry");
        $display("test charge complete done");
    endtask : t_charged

    task automatic t_lock;
        int bad;
        int hi;
        bad = 0;
        hi = 0;
        scheme <= 2'h1;
        sys_rst <= 1'b1;
        cycles(2);
        sys_rst <= 1'b0;
        wait_pwr(1'b1, 15 * MS);
        internal_fault <= 1'b1;
        wait_pwr(1'b0, 10);
        internal_fault <= 1'b0;
        cycles(10 * MS);
        repeat (1500 * MS) begin
            @(posedge clk_sys);
            bad += int'(power_enable !== 1'b0 || (led !== 3'b011 && led !== 3'b000));
            hi += int'(led === 3'b011);
        end
        check(bad == 0 && hi > 0, "lock hold or lamps");
        $display("test lock done");
    endtask : t_lock

    initial begin
        cycles(2);
        sys_rst <= 1'b0;
        t_startup();
        t_cep();
        t_status();
        t_cap();
        t_droop();
        t_retry();
        t_sense();
        t_charged();
        t_lock();
        complete_run();
    end
endmodule : wireless_tx_power_supervisor_tb
